// ---- include/mqw_consts.vh ----
// constants for the multi-queue write port select block
`ifndef MQW_CONSTS_VH
`define MQW_CONSTS_VH
`define MQW_ADDR_W        7
`define MQW_QSEL_W        4
`define MQW_DEV_LSB       4
`define MQW_DEV_W         3
`define MQW_NUM_Q         16
`define MQW_SECTORS       2
`define MQW_SEC_W         1
`define MQW_FLAG_W        8
`define MQW_SETUP_CYC     16'h0008
`define MQW_CNT_W         16
`define MQW_CNT_ONE       16'h0001
`define MQW_CNT_ZERO      16'h0000
`define MQW_Q_RST         4'h0
`define MQW_BUS_IDLE      8'hFF
`endif

// ---- logic/mqw_sync2.v ----
// two-stage synchroniser for a pin-level input
`timescale 1ns/1ps
`default_nettype none
module mqw_sync2 #(
    parameter W = 1
) (
    input  wire         mclk,
    input  wire         sys_rst,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_r;

    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            meta_r <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ---- logic/mqw_write_port.v ----
// write-port queue selection, flag bus and expansion token logic
//
// Summary of operation
// RULE1 - A high queue-select strobe loads the write address as the new write queue.
// RULE2 - The writer raises the queue-select strobe only on queue-change cycles.
// RULE3 - The writer never raises queue-select and flag-sector strobes together.
// RULE4 - The writer waits for program-done low before any queue selection.
// RULE5 - Each edge with write enable low stores the data word into the current queue.
// RULE6 - Queue selection is accepted regardless of write enable.
// RULE7 - Writes reach a newly selected queue from the second edge after selection.
// RULE8 - The almost-full bus cycles or selects its sector without write enable.
// RULE9 - In direct mode a flag-sector strobe picks the sector from the write address.
// RULE10 - In polled mode the almost-full bus steps through sectors with a frame sync.
// RULE11 - Almost-full bus, almost-full flag and full flag are updated on the clock.
// RULE12 - Expansion tokens are sampled and driven on the write clock.
// RULE13 - The writer supplies a free-running write clock.
// RULE14 - The low four address bits choose one of sixteen queues.
// RULE15 - A selection counts only when the upper three address bits match the device id.
// RULE16 - Program-done goes low once configuration has finished.
`timescale 1ns/1ps
`default_nettype none
`include "mqw_consts.vh"
module mqw_write_port #(
    parameter DATA_W  = 36,
    parameter DEPTH_W = 10,
    parameter [`MQW_DEV_W-1:0] DEVICE_ID = 3'h0
) (
    input  wire                   mclk,
    input  wire                   sys_rst,
    input  wire                   queue_select_strobe,
    input  wire [`MQW_ADDR_W-1:0] write_queue_address,
    input  wire                   flag_sector_strobe,
    input  wire                   write_en_n,
    input  wire [DATA_W-1:0]      din,
    input  wire                   polled_mode,
    input  wire                   expansion_token_in,
    input  wire [`MQW_NUM_Q-1:0]  queue_full,
    input  wire [`MQW_NUM_Q-1:0]  queue_almost_full,
    output reg                    program_done_out,
    output reg                    mem_wr_r,
    output reg  [`MQW_QSEL_W-1:0] mem_queue_r,
    output reg  [DATA_W-1:0]      mem_data_r,
    output reg  [`MQW_QSEL_W-1:0] write_queue_r,
    output reg  [`MQW_FLAG_W-1:0] almost_full_status_bus,
    output reg                    almost_full_flag,
    output reg                    full_flag,
    output reg                    flag_frame_sync,
    output reg                    expansion_token_out
);
    // ************************************************************
    // input capture
    // ************************************************************
    wire        tok_in_s;
    wire        polled_s;
    wire        addr_hit;
    reg         sel_pend_r;
    reg  [`MQW_QSEL_W-1:0] sel_q_r;
    reg  [`MQW_QSEL_W-1:0] active_q_r;
    reg  [`MQW_CNT_W-1:0]  setup_cnt_r;
    reg  [`MQW_SEC_W-1:0]  sector_r;
    reg  [`MQW_SEC_W-1:0]  sector_nxt;
    reg  [`MQW_FLAG_W-1:0] sector_flags;

    mqw_sync2 #(.W(2)) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .din     ({expansion_token_in, polled_mode}),
        .dout    ({tok_in_s, polled_s})
    );

    // RULE15 device id match
    assign addr_hit = (write_queue_address[`MQW_ADDR_W-1:`MQW_DEV_LSB] == DEVICE_ID);

    // ************************************************************
    // configuration done
    // ************************************************************
    // stand-in for serial setup: fixed count after reset
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            setup_cnt_r      <= `MQW_CNT_ZERO;
            program_done_out <= 1'b1;
        end
        else if (setup_cnt_r != `MQW_SETUP_CYC)
        begin
            setup_cnt_r <= setup_cnt_r + `MQW_CNT_ONE;
        end
        else
        begin
            // RULE16 ready for normal operation
            program_done_out <= 1'b0;
        end
    end

    // ************************************************************
    // queue selection
    // ************************************************************
    // back-to-back selections each keep their own two-edge latency
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sel_pend_r    <= 1'b0;
            sel_q_r       <= `MQW_Q_RST;
            active_q_r    <= `MQW_Q_RST;
            write_queue_r <= `MQW_Q_RST;
        end
        else
        begin
            sel_pend_r <= 1'b0;
            // RULE1 RULE6 RULE14 capture queue, ignore write enable
            if (queue_select_strobe && !flag_sector_strobe && addr_hit && !program_done_out)
            begin
                sel_q_r       <= write_queue_address[`MQW_QSEL_W-1:0];
                write_queue_r <= write_queue_address[`MQW_QSEL_W-1:0];
                sel_pend_r    <= 1'b1;
            end
            // RULE7 new queue live two edges after selection
            if (sel_pend_r)
            begin
                active_q_r <= sel_q_r;
            end
        end
    end

    // ************************************************************
    // write path to queue memory
    // ************************************************************
    // words on the select edge and the next still land in the old queue
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            mem_wr_r    <= 1'b0;
            mem_queue_r <= `MQW_Q_RST;
            mem_data_r  <= {DATA_W{1'b0}};
        end
        else
        begin
            // RULE5 store word into current queue
            mem_wr_r    <= !write_en_n;
            mem_queue_r <= active_q_r;
            mem_data_r  <= din;
        end
    end

    // ************************************************************
    // almost-full flag bus
    // ************************************************************
    always @*
    begin
        sector_nxt = sector_r;
        // RULE8 RULE9 direct mode sector pick, no write enable needed
        if (!polled_s && flag_sector_strobe && !queue_select_strobe)
        begin
            sector_nxt = write_queue_address[`MQW_SEC_W-1:0];
        end
        // RULE10 polled mode steps every edge
        else if (polled_s)
        begin
            sector_nxt = sector_r + 1'b1;
        end
        sector_flags = sector_nxt[0] ? queue_almost_full[`MQW_NUM_Q-1:`MQW_FLAG_W]
                                     : queue_almost_full[`MQW_FLAG_W-1:0];
    end

    // ************************************************************
    // almost-full status bus register
    // ************************************************************
    // bus loads the sector it moves to, so bus data and frame sync agree
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sector_r               <= 1'b0;
            almost_full_status_bus <= `MQW_BUS_IDLE;
        end
        else
        begin
            sector_r               <= sector_nxt;
            // RULE11 bus registered on the write clock, active low
            almost_full_status_bus <= ~sector_flags;
        end
    end

    // ************************************************************
    // active queue flags
    // ************************************************************
    // flags track the queue being written now, not the one just named
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            almost_full_flag <= 1'b1;
            full_flag        <= 1'b1;
        end
        else
        begin
            // RULE11 flags registered on the write clock, active low
            almost_full_flag <= ~queue_almost_full[active_q_r];
            full_flag        <= ~queue_full[active_q_r];
        end
    end

    // ************************************************************
    // frame sync and expansion token
    // ************************************************************
    // two sync stages plus this one: token lags three edges end to end
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            flag_frame_sync     <= 1'b0;
            expansion_token_out <= 1'b0;
        end
        else
        begin
            // RULE10 frame sync marks sector zero in polled mode
            flag_frame_sync     <= polled_s && (sector_nxt == 1'b0);
            // RULE12 token passed on the write clock
            expansion_token_out <= tok_in_s;
        end
    end
endmodule
`default_nettype wire

// ---- tb/mqw_write_port_assertions.sv ----
// checker for the write port select block
`timescale 1ns/1ps
`default_nettype none
`include "mqw_consts.vh"
module mqw_chk #(
    parameter DATA_W = 36
) (
    input wire logic                   mclk,
    input wire logic                   sys_rst,
    input wire logic                   queue_select_strobe,
    input wire logic [`MQW_ADDR_W-1:0] write_queue_address,
    input wire logic                   flag_sector_strobe,
    input wire logic                   write_en_n,
    input wire logic [DATA_W-1:0]      din,
    input wire logic                   expansion_token_in,
    input wire logic                   program_done_out,
    input wire logic                   mem_wr_r,
    input wire logic [`MQW_QSEL_W-1:0] mem_queue_r,
    input wire logic [DATA_W-1:0]      mem_data_r,
    input wire logic [`MQW_QSEL_W-1:0] write_queue_r,
    input wire logic                   flag_frame_sync,
    input wire logic                   expansion_token_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire ok_sel = queue_select_strobe && !flag_sector_strobe && !program_done_out
                  && write_queue_address[6:4] == 3'h0;
    a_sel_loads_queue:
        assert property (ok_sel |=> write_queue_r == $past(write_queue_address[3:0]))
        else $error("queue select not taken");
    a_sel_refused:
        assert property (!ok_sel |=> $stable(write_queue_r)) else $error("queue changed");
    a_word_stored:
        assert property (!write_en_n && !program_done_out |=> mem_wr_r && mem_data_r == $past(din))
        else $error("word not stored");
    a_no_stray_write:
        assert property (write_en_n |=> !mem_wr_r) else $error("write without enable");
    a_new_queue_lag:
        assert property (mem_wr_r |-> mem_queue_r == $past(write_queue_r, 2))
        else $error("write went to wrong queue");
    a_done_in_time:
        assert property ($fell(sys_rst) |-> ##[0:10] !program_done_out) else $error("done late");
    a_done_holds:
        assert property (!program_done_out |=> !program_done_out) else $error("done rose");
    a_sync_steps:
        assert property (flag_frame_sync |=> !flag_frame_sync) else $error("sync not stepping");
    a_token_delay:
        assert property (expansion_token_out == $past(expansion_token_in, 3))
        else $error("token delay wrong");
endmodule
bind mqw_write_port mqw_chk #(.DATA_W(DATA_W)) u_chk (
    .mclk                (mclk),
    .sys_rst             (sys_rst),
    .queue_select_strobe (queue_select_strobe),
    .write_queue_address (write_queue_address),
    .flag_sector_strobe  (flag_sector_strobe),
    .write_en_n          (write_en_n),
    .din                 (din),
    .expansion_token_in  (expansion_token_in),
    .program_done_out    (program_done_out),
    .mem_wr_r            (mem_wr_r),
    .mem_queue_r         (mem_queue_r),
    .mem_data_r          (mem_data_r),
    .write_queue_r       (write_queue_r),
    .flag_frame_sync     (flag_frame_sync),
    .expansion_token_out (expansion_token_out)
);
`default_nettype wire

// ---- tb/mqw_writer.sv ----
// writer model driving the block's write port
`timescale 1ns/1ps
`default_nettype none
module mqw_writer (
    input  wire logic   mclk,
    output logic        queue_select_strobe,
    output logic [6:0]  write_queue_address,
    output logic        flag_sector_strobe,
    output logic        write_en_n,
    output logic [35:0] din,
    output logic        expansion_token_in
);
    initial
    begin
        {queue_select_strobe, write_queue_address, flag_sector_strobe, din} = '0;
        expansion_token_in = 1'b0;
        write_en_n = 1'b1;
    end
    task cyc(input logic q, input logic [6:0] a, input logic f, input logic w,
             input logic [35:0] d);
        {queue_select_strobe, write_queue_address, flag_sector_strobe} = {q, a, f};
        {write_en_n, din, expansion_token_in} = {w, d, d[0]};
        @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the write port select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0, sys_rst = 1'b1, polled_mode = 1'b0, done, wr, sync, qs, fs, wen_n, tin;
    logic [6:0] addr;
    logic [35:0] din, mdat;
    logic [3:0] mq, wq;
    logic [7:0] bus;
    logic aff, ff, tout;
    int n_errors = 0, compares = 0, k, n = 0;
    always #5 mclk = ~mclk;
    mqw_writer w (.mclk(mclk), .queue_select_strobe(qs), .write_queue_address(addr),
        .flag_sector_strobe(fs), .write_en_n(wen_n), .din(din), .expansion_token_in(tin));
    mqw_write_port dut (.mclk(mclk), .sys_rst(sys_rst), .queue_select_strobe(qs),
        .write_queue_address(addr), .flag_sector_strobe(fs), .write_en_n(wen_n), .din(din),
        .polled_mode(polled_mode), .expansion_token_in(tin), .queue_full(16'hF00F),
        .queue_almost_full(16'h0FF0), .program_done_out(done), .mem_wr_r(wr),
        .mem_queue_r(mq), .mem_data_r(mdat), .write_queue_r(wq), .almost_full_status_bus(bus),
        .almost_full_flag(aff), .full_flag(ff), .flag_frame_sync(sync),
        .expansion_token_out(tout));
    task chk(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #5000;
        n_errors++;
        print_verdict;
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        #1 sys_rst = 1'b0;
        // wait for configuration
        // look off the edge so the read never races the flop update
        for (k = 0; k < 40 && done !== 1'b0; k++)
        begin
            @(posedge mclk);
            #1;
        end
        chk(done, 36'h0);
        w.cyc(1'b1, 7'h05, 1'b0, 1'b0, 36'h00000000A);
        chk(mq, 36'h0);
        chk(mdat, 36'h00000000A);
        w.cyc(1'b0, 7'h05, 1'b0, 1'b0, 36'h00000000B);
        chk(mq, 36'h0);
        chk(wq, 36'h5);
        w.cyc(1'b0, 7'h05, 1'b0, 1'b0, 36'h00000000C);
        chk(mq, 36'h5);
        chk(ff, 36'h1);
        chk(aff, 36'h0);
        w.cyc(1'b1, 7'h0F, 1'b0, 1'b1, 36'h0);
        chk(wr, 36'h0);
        w.cyc(1'b1, 7'h13, 1'b0, 1'b1, 36'h0);
        chk(wq, 36'hF);
        w.cyc(1'b1, 7'h02, 1'b1, 1'b1, 36'h0);
        chk(wq, 36'hF);
        w.cyc(1'b0, 7'h00, 1'b0, 1'b1, 36'h0);
        chk(wq, 36'hF);
        chk(ff, 36'h0);
        chk(aff, 36'h1);
        chk(bus, 36'h0F);
        w.cyc(1'b0, 7'h01, 1'b1, 1'b1, 36'h0);
        chk(bus, 36'hF0);
        $display("test select done");
        polled_mode = 1'b1;
        for (k = 0; k < 12; k++)
        begin
            w.cyc(1'b0, 7'h00, 1'b0, 1'b1, 36'(k % 3));
            if (k > 3)
            begin
                n += int'(sync);
                chk(bus, (k % 2 == 0) ? 36'h0F : 36'hF0);
                chk(tout, 36'(k % 3 == 0));
            end
        end
        chk(36'(n), 36'h4);
        $display("test polled done");
        print_verdict;
    end
endmodule
`default_nettype wire
